/* bench/wed_fields_test.sv */
// Self-checking bench for the descriptor field encoder
`timescale 1ns/1ps
`default_nettype none
module wed_fields_test import wed_pkg::*;;
	typedef struct packed {
		logic [31:0] cfg;
		logic [31:0] size;
		logic [7:0]  attr;
		logic [15:0] mps;
		logic [7:0]  ivl;
		logic        err;
	} wed_row_s;
	logic        clk_i = 1'h0;
	logic        sys_rst_i = 1'h1;
	logic        clk_en_i = 1'h1;
	logic        hresp_o;
	logic        hsel_i = 1'h0;
	logic [31:0] haddr_i = 32'h0;
	logic [1:0]  htrans_i = 2'h0;
	logic        hwrite_i = 1'h0;
	logic [31:0] hwdata_i = 32'h0;
	logic [31:0] hrdata_o;
	logic        hreadyout_o;
	logic        desc_err_o;
	wed_desc_s   desc_o;
	logic        bad;
	logic [15:0] period;
	logic [31:0] rd;
	int          miscompares = 0;
	int          compares = 0;
	wed_row_s    rows [10] = '{
		'{32'h0000_06FE, 32'h0000_0200, 8'h82, 16'h0200, 8'h00, 1'h0},
		'{32'h0000_0500, 32'h0001_0040, 8'h00, 16'h0040, 8'h00, 1'h0},
		'{32'h0000_104F, 32'h0000_0008, 8'h07, 16'h0008, 8'h10, 1'h0},
		'{32'h0000_012D, 32'h0300_0100, 8'h2D, 16'h0300, 8'h01, 1'h0},
		'{32'h0001_10C1, 32'h0000_FFFF, 8'h81, 16'hFFFF, 8'h10, 1'h0},
		'{32'h0000_0503, 32'h0000_0040, 8'h03, 16'h0040, 8'h06, 1'h1},
		'{32'h0000_1103, 32'h0000_0040, 8'h03, 16'h0040, 8'h10, 1'h1},
		'{32'h0000_0001, 32'h0000_0040, 8'h01, 16'h0040, 8'h01, 1'h1},
		'{32'h0000_0431, 32'h0000_0040, 8'h31, 16'h0040, 8'h04, 1'h1},
		'{32'h0000_0613, 32'h0008_0040, 8'h13, 16'h0040, 8'h06, 1'h0}};

	always #2.5 clk_i = ~clk_i;

	wed_fields DUT (
		.clk_i(clk_i), .sys_rst_i(sys_rst_i), .clk_en_i(clk_en_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2),
		.hwdata_i(hwdata_i), .hready_i(hreadyout_o), .hrdata_o(hrdata_o),
		.hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .desc_o(desc_o), .desc_err_o(desc_err_o));

	wed_host host (.desc_i(desc_o), .bad_o(bad), .period_o(period));

	task automatic complete_run;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	task automatic wait_rdy;
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (hreadyout_o !== 1'h1 && n < 64);
		if (hreadyout_o !== 1'h1) begin
			miscompares++;
			complete_run();
		end
	endtask : wait_rdy

	// ==========
	// Single word transfer, read data left in rd
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		hsel_i   <= 1'h1;
		htrans_i <= 2'h2;
		haddr_i  <= {24'h0, a};
		hwrite_i <= w;
		wait_rdy();
		hsel_i   <= 1'h0;
		htrans_i <= 2'h0;
		hwdata_i <= w ? d : 32'h0;
		wait_rdy();
		rd = hrdata_o;
	endtask : xfer

	task automatic rst_chk;
		sys_rst_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		sys_rst_i <= 1'h0;
		@(posedge clk_i);
		#1;
		chk("rst desc", {8'h02, 16'h0040, 8'h00}, desc_o);
		chk("rst err", 32'h0, {31'h0, desc_err_o});
		xfer(1'h0, WED_CFG_OFF, 32'h0);
		chk("rst cfg", 32'h0000_0602, rd);
		xfer(1'h0, WED_SIZE_OFF, 32'h0);
		chk("rst size", 32'h0000_0040, rd);
		chk("resp", 32'h0, {31'h0, hresp_o});
	endtask : rst_chk

	initial begin
		rst_chk();
		foreach (rows[i]) begin
			xfer(1'h1, WED_SIZE_OFF, rows[i].size);
			xfer(1'h1, WED_CFG_OFF, rows[i].cfg);
			@(posedge clk_i);
			#1;
			chk("attr", {24'h0, rows[i].attr}, {24'h0, desc_o.attr});
			chk("mps", {16'h0, rows[i].mps}, {16'h0, desc_o.max_pkt});
			chk("ivl", {24'h0, rows[i].ivl}, {24'h0, desc_o.interval});
			chk("err", {31'h0, rows[i].err}, {31'h0, desc_err_o});
			chk("host bad", 32'h0, {31'h0, bad});
			xfer(1'h0, WED_OUT_OFF, 32'h0);
			chk("out", {rows[i].ivl, rows[i].mps, rows[i].attr}, rd);
			xfer(1'h0, WED_STAT_OFF, 32'h0);
			chk("stat", {31'h0, rows[i].err}, rd);
		end
		chk("period", 32'h0000_0020, {16'h0, period});
		xfer(1'h1, WED_CFG_OFF, 32'hFFFF_FFFF);
		xfer(1'h0, WED_CFG_OFF, 32'h0);
		chk("cfg mask", 32'h0001_FFFF, rd);
		chk("clamp err", 32'h1, {31'h0, desc_err_o});
		xfer(1'h1, WED_STAT_OFF, 32'h0);
		xfer(1'h0, WED_STAT_OFF, 32'h0);
		chk("stat ro", 32'h1, rd);
		xfer(1'h1, 8'h10, 32'hA5A5_A5A5);
		xfer(1'h0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
		// Clock enable low: a write must not land
		clk_en_i <= 1'h0;
		xfer(1'h1, WED_CFG_OFF, 32'h0000_0602);
		clk_en_i <= 1'h1;
		xfer(1'h0, WED_CFG_OFF, 32'h0);
		chk("frozen cfg", 32'h0001_FFFF, rd);
		rst_chk();
		complete_run();
	end
endmodule : wed_fields_test
`default_nettype wire

/* bench/wed_host.sv */
// Host-side reader of the encoded descriptor fields
`timescale 1ns/1ps
`default_nettype none
module wed_host import wed_pkg::*; (
	input  wire wed_desc_s desc_i,
	output logic           bad_o,
	output logic [15:0]    period_o
);
	// Reserved bits and interval range per transfer type
	always_comb begin
		case (desc_i.attr[1:0])
			WED_TT_INTR: bad_o = desc_i.attr[3] | desc_i.attr[6]
				| (desc_i.interval < WED_INTR_IVL_MIN) | (desc_i.interval > WED_INTR_IVL_MAX);
			WED_TT_ISO: bad_o = desc_i.attr[6]
				| (desc_i.interval < WED_ISO_IVL_MIN) | (desc_i.interval > WED_ISO_IVL_MAX);
			default: bad_o = (|desc_i.attr[6:2]) | (|desc_i.interval);
		endcase
	end
	// Polling period in 128 us units
	assign period_o = 16'h0001 << (desc_i.interval - 8'h01);
endmodule : wed_host
`default_nettype wire

/* src/wed_fields.sv */
// Encoder and checker for wireless endpoint descriptor fields, AHB-Lite slave
// Operation
// - Non-iso packet size field at offset 4
// - Iso packet size is the logical size
// - Packet size equals over-air size when allowed
// - Scalable iso reports largest packet size (scalable bit is stored but unused, size taken as written)
// - All sixteen bits give byte count
// - Interval byte zero for bulk, control
// - Interrupt period is two to n-1 units
// - Interrupt interval between 6 and 16
// - Iso interval 1 to 16, 125us units
// - Scalable iso reports fastest service rate (scalable bit is stored but unused, interval taken as written)
// - Attribute bits 6:2 zero for bulk, control
// - Interrupt bit 2 gives power mode
// - Interrupt usage in 5:4, 3 and 6 zero
// - Iso bits 5:2 sync and usage, 6 zero
// - Bit 7 flags packet size adjustment
// - Bits 1:0 code the transfer type
// - Power bit 0 normal, 1 low
`timescale 1ns/1ps
`default_nettype none

module wed_fields (
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	input  wire logic                 clk_en_i,
	input  wire logic                 hsel_i,
	input  wire logic [31:0]          haddr_i,
	input  wire logic [1:0]           htrans_i,
	input  wire logic                 hwrite_i,
	input  wire logic [2:0]           hsize_i,
	input  wire logic [31:0]          hwdata_i,
	input  wire logic                 hready_i,
	output logic      [31:0]          hrdata_o,
	output logic                      hreadyout_o,
	output logic                      hresp_o,
	output var wed_pkg::wed_desc_s    desc_o,
	output logic                      desc_err_o
);
	import wed_pkg::*;

	// ==========================================
	// Registers
	logic [31:0] cfg_q;
	logic [31:0] size_q;
	wed_desc_s   desc_q;
	logic        err_q;
	logic        wr_pend_q;
	logic [7:0]  addr_q;
	wed_bus_e    st_q;
	wed_cfg_s    cfg;
	wed_desc_s   desc_d;
	logic        err_d;
	logic [15:0] mps;
	logic [15:0] ota;
	logic        ota_ok;
	logic [7:0]  ivl_lo;
	logic [7:0]  ivl_hi;
	logic [31:0] rd_d;
	logic [31:0] rdata_q;
	logic        take;

	assign cfg = wed_cfg_s'({cfg_q[WED_CFG_SCAL_BIT], cfg_q[WED_CFG_IVL_LSB +: 8],
		cfg_q[WED_CFG_ADJ_BIT], cfg_q[WED_CFG_USE_LSB +: 2], cfg_q[WED_CFG_SYNC_LSB +: 2],
		cfg_q[WED_CFG_PWR_BIT], cfg_q[WED_CFG_TT_LSB +: 2]});
	assign mps = size_q[WED_SIZE_MPS_LSB +: 16];
	assign ota = size_q[WED_SIZE_OTA_LSB +: 16];
	// Over-air value zero means a software compatibility issue
	assign ota_ok = (ota != 16'h0000);

	// ==========================================
	// Field encoder
	always_comb begin
		desc_d = '0;
		err_d  = 1'b0;
		ivl_lo = 8'h00;
		ivl_hi = 8'h00;
		desc_d.attr[1:0] = cfg.ttype;
		desc_d.attr[7]   = cfg.adjust;
		desc_d.max_pkt   = mps;
		case (cfg.ttype)
			WED_TT_ISO: begin
				// Logical size, or over-air size when compatible
				desc_d.max_pkt = ota_ok ? ota : mps;
				desc_d.attr[3:2] = cfg.sync;
				desc_d.attr[5:4] = cfg.usage;
				desc_d.interval  = cfg.interval;
				ivl_lo = WED_ISO_IVL_MIN;
				ivl_hi = WED_ISO_IVL_MAX;
			end
			WED_TT_INTR: begin
				desc_d.attr[2]   = cfg.power;
				desc_d.attr[5:4] = cfg.usage;
				desc_d.interval  = cfg.interval;
				ivl_lo = WED_INTR_IVL_MIN;
				ivl_hi = WED_INTR_IVL_MAX;
				err_d  = cfg.usage[1];
			end
			default: begin
				desc_d.interval = 8'h00;
			end
		endcase
		if (cfg.ttype == WED_TT_ISO && cfg.usage == 2'h3) begin
			err_d = 1'b1;
		end
		// Out-of-range interval is reported, and clamped into range
		if (ivl_hi != 8'h00) begin
			if (desc_d.interval < ivl_lo) begin
				err_d = 1'b1;
				desc_d.interval = ivl_lo;
			end else if (desc_d.interval > ivl_hi) begin
				err_d = 1'b1;
				desc_d.interval = ivl_hi;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			desc_q <= '0;
			err_q  <= 1'b0;
		end else if (clk_en_i) begin
			desc_q <= desc_d;
			err_q  <= err_d;
		end
	end

	assign desc_o     = desc_q;
	assign desc_err_o = err_q;

	// ==========================================
	// AHB-Lite slave
	assign take = hsel_i && hready_i && htrans_i[1];

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st_q      <= WED_ST_IDLE;
			wr_pend_q <= 1'b0;
			addr_q    <= 8'h00;
		end else if (clk_en_i) begin
			case (st_q)
				WED_ST_IDLE: begin
					st_q <= take ? WED_ST_DATA : WED_ST_IDLE;
				end
				WED_ST_DATA: begin
					st_q <= take ? WED_ST_DATA : WED_ST_IDLE;
				end
				default: begin
					st_q <= WED_ST_IDLE;
				end
			endcase
			wr_pend_q <= take && hwrite_i;
			if (take) begin
				addr_q <= haddr_i[7:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			cfg_q  <= WED_CFG_RST;
			size_q <= WED_SIZE_RST;
		end else if (clk_en_i && wr_pend_q && st_q == WED_ST_DATA) begin
			case (addr_q)
				WED_CFG_OFF:  cfg_q  <= hwdata_i & 32'h0001_FFFF;
				WED_SIZE_OFF: size_q <= hwdata_i;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		case (haddr_i[7:0])
			WED_CFG_OFF:  rd_d = cfg_q;
			WED_SIZE_OFF: rd_d = size_q;
			WED_OUT_OFF:  rd_d = {desc_q.interval, desc_q.max_pkt, desc_q.attr};
			WED_STAT_OFF: rd_d = {31'h0000_0000, err_q};
			default:      rd_d = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h0000_0000;
		end else if (clk_en_i && take && !hwrite_i) begin
			rdata_q <= rd_d;
		end
	end

	assign hrdata_o    = rdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;

	// ==========================================
	// Checks
	property p_bulk_ctrl_zero;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !cfg.ttype[0]) |=> (desc_o.interval == 8'h00 && desc_o.attr[6:2] == 5'h00);
	endproperty
	a_bulk_ctrl_zero: assert property (p_bulk_ctrl_zero)
		else $error("bulk or control field not zero");

	property p_reserved_bits;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i) |=> !desc_o.attr[6];
	endproperty
	a_reserved_bits: assert property (p_reserved_bits)
		else $error("attribute bit 6 not zero");

	property p_tt_code;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i) |=> desc_o.attr[1:0] == $past(cfg.ttype);
	endproperty
	a_tt_code: assert property (p_tt_code)
		else $error("transfer type code wrong");

	property p_intr_range;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg.ttype == WED_TT_INTR) |=>
			(desc_o.interval >= WED_INTR_IVL_MIN && desc_o.interval <= WED_INTR_IVL_MAX
			&& !desc_o.attr[3] && !desc_o.attr[6]);
	endproperty
	a_intr_range: assert property (p_intr_range)
		else $error("interrupt interval or reserved bits wrong");

	property p_intr_power;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg.ttype == WED_TT_INTR) |=> desc_o.attr[2] == $past(cfg.power);
	endproperty
	a_intr_power: assert property (p_intr_power)
		else $error("power mode bit wrong");

	property p_iso_range;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg.ttype == WED_TT_ISO) |=>
			(desc_o.interval >= WED_ISO_IVL_MIN && desc_o.interval <= WED_ISO_IVL_MAX
			&& !desc_o.attr[6]);
	endproperty
	a_iso_range: assert property (p_iso_range)
		else $error("iso interval out of range");

	property p_iso_size;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && cfg.ttype == WED_TT_ISO && ota != 16'h0000) |=>
			desc_o.max_pkt == $past(ota);
	endproperty
	a_iso_size: assert property (p_iso_size)
		else $error("iso size not over-air size");

	property p_size_bytes;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i && cfg.ttype != WED_TT_ISO) |=> desc_o.max_pkt == $past(mps);
	endproperty
	a_size_bytes: assert property (p_size_bytes)
		else $error("packet size field wrong");

	property p_adjust;
		@(posedge clk_i) disable iff (sys_rst_i)
		clk_en_i |=> desc_o.attr[7] == $past(cfg.adjust);
	endproperty
	a_adjust: assert property (p_adjust)
		else $error("adjust flag wrong");

	property p_intr_usage;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i && cfg.ttype == WED_TT_INTR) |=>
			desc_o.attr[5:4] == $past(cfg.usage);
	endproperty
	a_intr_usage: assert property (p_intr_usage)
		else $error("interrupt usage bits wrong");

	property p_iso_attr;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i && cfg.ttype == WED_TT_ISO) |=>
			desc_o.attr[5:2] == $past({cfg.usage, cfg.sync});
	endproperty
	a_iso_attr: assert property (p_iso_attr)
		else $error("iso sync or usage bits wrong");

	// Without a usable over-air size the logical size is reported
	property p_iso_logical;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i && cfg.ttype == WED_TT_ISO && ota == 16'h0000) |=>
			desc_o.max_pkt == $past(mps);
	endproperty
	a_iso_logical: assert property (p_iso_logical)
		else $error("iso logical size wrong");

	property p_intr_err;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i && cfg.ttype == WED_TT_INTR
			&& (cfg.interval < WED_INTR_IVL_MIN || cfg.interval > WED_INTR_IVL_MAX)) |=>
			desc_err_o;
	endproperty
	a_intr_err: assert property (p_intr_err)
		else $error("interrupt interval error not flagged");

	// An in-range service interval passes through unchanged
	property p_iso_ivl;
		@(posedge clk_i) disable iff (sys_rst_i)
		(clk_en_i && !sys_rst_i && cfg.ttype == WED_TT_ISO
			&& cfg.interval >= WED_ISO_IVL_MIN && cfg.interval <= WED_ISO_IVL_MAX) |=>
			desc_o.interval == $past(cfg.interval);
	endproperty
	a_iso_ivl: assert property (p_iso_ivl)
		else $error("iso service interval altered");

endmodule : wed_fields

`default_nettype wire

/* src/wed_pkg.sv */
// Package for the wireless endpoint descriptor field encoder
package wed_pkg;

	// ==========================================
	// Register map (byte addresses)
	localparam logic [7:0] WED_CFG_OFF  = 8'h00;
	localparam logic [7:0] WED_SIZE_OFF = 8'h04;
	localparam logic [7:0] WED_OUT_OFF  = 8'h08;
	localparam logic [7:0] WED_STAT_OFF = 8'h0C;

	// ==========================================
	// Descriptor byte offsets
	localparam logic [7:0] WED_DESC_ATTR_OFF = 8'h03;
	localparam logic [7:0] WED_DESC_MPS_OFF  = 8'h04;
	localparam logic [7:0] WED_DESC_IVL_OFF  = 8'h06;

	// ==========================================
	// Transfer type codes in attribute bits 1:0
	localparam logic [1:0] WED_TT_CTRL = 2'h0;
	localparam logic [1:0] WED_TT_ISO  = 2'h1;
	localparam logic [1:0] WED_TT_BULK = 2'h2;
	localparam logic [1:0] WED_TT_INTR = 2'h3;

	// Interrupt power mode bit values
	localparam logic WED_PWR_NORMAL = 1'b0;
	localparam logic WED_PWR_LOW    = 1'b1;

	// ==========================================
	// Interval limits
	localparam logic [7:0] WED_INTR_IVL_MIN = 8'h06;
	localparam logic [7:0] WED_INTR_IVL_MAX = 8'h10;
	localparam logic [7:0] WED_ISO_IVL_MIN  = 8'h01;
	localparam logic [7:0] WED_ISO_IVL_MAX  = 8'h10;
	localparam int         WED_INTR_UNIT_US = 128;
	localparam int         WED_ISO_UNIT_US  = 125;

	// ==========================================
	// Reset values
	localparam logic [31:0] WED_CFG_RST  = 32'h0000_0602;
	localparam logic [31:0] WED_SIZE_RST = 32'h0000_0040;

	// CFG field positions
	localparam int WED_CFG_TT_LSB   = 0;
	localparam int WED_CFG_PWR_BIT  = 2;
	localparam int WED_CFG_SYNC_LSB = 2;
	localparam int WED_CFG_USE_LSB  = 4;
	localparam int WED_CFG_ADJ_BIT  = 7;
	localparam int WED_CFG_IVL_LSB  = 8;
	localparam int WED_CFG_SCAL_BIT = 16;

	// SIZE field positions
	localparam int WED_SIZE_MPS_LSB = 0;
	localparam int WED_SIZE_OTA_LSB = 16;

	// Endpoint setup written by software
	typedef struct packed {
		logic       scalable;
		logic [7:0] interval;
		logic       adjust;
		logic [1:0] usage;
		logic [1:0] sync;
		logic       power;
		logic [1:0] ttype;
	} wed_cfg_s;

	// Encoded descriptor fields
	typedef struct packed {
		logic [7:0]  attr;
		logic [15:0] max_pkt;
		logic [7:0]  interval;
	} wed_desc_s;

	typedef enum logic [1:0] {
		WED_ST_IDLE,
		WED_ST_DATA
	} wed_bus_e;

endpackage : wed_pkg
